// *** bench/blr_mem_model.sv ***
// Behavioural external boot memory answering one byte read at a time
`timescale 1ns/1ps
`default_nettype none
module blr_mem_model (
	// Clock and restart
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        slow,
	// Read port
	input  wire logic        memRdReq,
	input  wire logic [31:0] memRdAddr,
	output logic             memRdAck,
	output logic [7:0]       memRdData
);
	logic [7:0] image [256];
	logic [1:0] waitCnt;

	initial begin
		memRdAck = 1'b0;
		memRdData = 8'h00;
		waitCnt = 2'h0;
	end

	// Ack after optional wait states; data is junk outside the ack cycle
	always @(posedge core_clk) begin
		if (rst || memRdAck) begin
			memRdAck <= 1'b0;
			memRdData <= ~memRdData;
			waitCnt <= 2'h0;
		end else if (memRdReq && (!slow || waitCnt == 2'h3)) begin
			memRdAck <= 1'b1;
			memRdData <= image[memRdAddr[7:0]];
		end else begin
			memRdData <= ~memRdData;
			if (memRdReq)
				waitCnt <= waitCnt + 2'h1;
		end
	end
endmodule : blr_mem_model
`default_nettype wire

// *** bench/boot_mode_rom_loader_bench.sv ***
// Self-checking bench for the boot source sequencer
`timescale 1ns/1ps
`default_nettype none
module boot_mode_rom_loader_bench;
	import blr_pkg::*;
	logic core_clk = 1'b0, srst = 1'b1, softReset = 1'b0, skipWrEn = 1'b0;
	logic skipWrVal = 1'b0, blockLoadEn = 1'b0, slow = 1'b0;
	logic [2:0] bootSourceSelect = 3'h0;
	logic [15:0] resetConfigStatus;
	logic memRdReq, memRdAck, l2WrEn, jumpValid, bootBusy, halted;
	logic [31:0] memRdAddr, l2WrAddr, jumpAddr, jAddr;
	logic [7:0] memRdData, l2WrData;
	logic [1:0] memPortKind;
	logic [39:0] wrQ[$], expQ[$];
	logic [31:0] seed = 32'h0000_9766;
	int bad_count = 0, checked = 0, jumps, reads;
	logic [2:0] curSel;
	logic skipExp = 1'b0;

	boot_mode_rom_loader dut (.core_clk(core_clk), .srst(srst),
		.bootSourceSelect(bootSourceSelect), .softReset(softReset),
		.skipWrEn(skipWrEn), .skipWrVal(skipWrVal), .blockLoadEn(blockLoadEn),
		.resetConfigStatus(resetConfigStatus), .memRdReq(memRdReq),
		.memRdAddr(memRdAddr), .memRdAck(memRdAck), .memRdData(memRdData),
		.memPortKind(memPortKind), .l2WrEn(l2WrEn), .l2WrAddr(l2WrAddr),
		.l2WrData(l2WrData), .jumpValid(jumpValid), .jumpAddr(jumpAddr),
		.bootBusy(bootBusy), .halted(halted));
	blr_mem_model mem (.core_clk(core_clk), .rst(srst || softReset),
		.slow(slow), .memRdReq(memRdReq), .memRdAddr(memRdAddr),
		.memRdAck(memRdAck), .memRdData(memRdData));

	// Clock and hang guard
	always #20 core_clk = ~core_clk;
	initial begin
		#(40 * 30000);
		bad_count++;
		end_of_test();
	end

	// Record writes, jumps and taken reads outside resets
	always @(posedge core_clk) begin
		if (!srst && !softReset) begin
			if (l2WrEn === 1'b1)
				wrQ.push_back({l2WrAddr, l2WrData});
			if (jumpValid === 1'b1) begin
				jumps++;
				jAddr = jumpAddr;
			end
			if (memRdReq === 1'b1 && memRdAck === 1'b1)
				reads++;
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [1:0] kindOf(input logic [2:0] s);
		return s == 3'h1 ? PORT_PAR : s == 3'h2 ? PORT_SER8 :
			s == 3'h3 ? PORT_SER16 : PORT_NONE;
	endfunction : kindOf

	task automatic chk(input string what, input logic [39:0] e, g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// One boot: build image and expectations, reset, wait, compare
	task automatic boot(input logic [2:0] sel, input int n, input bit hw, blk);
		int nRd, p;
		logic [31:0] jExp;
		logic full;
		// Zero block of two bytes, then final block of one byte
		logic [7:0] tagImg [21] = '{8'h00, 8'h01, 8'h00, 8'hF0, 8'h02, 8'h00,
			8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'hF0, 8'h01,
			8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'hA5};
		nRd = 0;
		expQ.delete();
		if (hw) begin
			curSel = sel;
			skipExp = 1'b0;
		end
		full = !(!hw && skipExp) && curSel inside {3'h1, 3'h2, 3'h3};
		jExp = (!hw && skipExp) ? L2_START : (curSel == 3'h0) ? BYPASS_ADDR :
			L2_START;
		for (int i = 0; i < 4; i++)
			mem.image[i] = 8'(n >> (8 * i));
		// Only a full boot copies anything into level two
		for (int i = 0; i < n; i++) begin
			mem.image[4 + i] = 8'(rnd());
			if (full)
				expQ.push_back({L2_START + 32'(i), mem.image[4 + i]});
		end
		if (blk) begin
			p = 4 + n;
			foreach (tagImg[k])
				mem.image[p + k] = tagImg[k];
			expQ.push_back({32'hF000_0100, 8'h00});
			expQ.push_back({32'hF000_0101, 8'h00});
			expQ.push_back({32'hF000_0200, 8'hA5});
		end
		if (full)
			nRd = 4 + n + (blk ? 21 : 0);
		blockLoadEn <= blk;
		slow <= 1'(rnd());
		if (hw) begin
			bootSourceSelect <= sel;
			srst <= 1'b1;
			repeat (3) @(posedge core_clk);
			srst <= 1'b0;
			bootSourceSelect <= ~sel;
		end else begin
			softReset <= 1'b1;
			@(posedge core_clk);
			softReset <= 1'b0;
		end
		wrQ.delete();
		jumps = 0;
		reads = 0;
		for (int c = 0; c < 900 && jumps == 0 && halted !== 1'b1; c++)
			@(posedge core_clk);
		repeat (8) @(posedge core_clk);
		chk("select", curSel, resetConfigStatus[2:0]);
		chk("reads", nRd, reads);
		chk("write count", expQ.size(), wrQ.size());
		foreach (expQ[i])
			if (i < wrQ.size())
				chk("write", expQ[i], wrQ[i]);
		chk("halted", curSel[2] && !(!hw && skipExp), halted);
		chk("jumps", !(curSel[2] && !(!hw && skipExp)), jumps);
		chk("busy", 1'b0, bootBusy);
		if (jumps == 1)
			chk("jump address", jExp, jAddr);
		if (full)
			chk("port kind", kindOf(curSel), memPortKind);
	endtask : boot

	// Every select, then count zero, skip on and off, tagged blocks
	initial begin
		for (int s = 0; s < 8; s++)
			boot(3'(s), 1 + (rnd() & 7), 1, 0);
		boot(3'h1, 0, 1, 0);
		boot(3'h1, 0, 1, 1);
		skipWrEn <= 1'b1;
		skipWrVal <= 1'b1;
		@(posedge core_clk);
		skipWrEn <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("skip bit", 1'b1, resetConfigStatus[CFG_SKIP_BIT]);
		skipExp = 1'b1;
		boot(3'h2, 3, 0, 0);
		skipWrEn <= 1'b1;
		skipWrVal <= 1'b0;
		@(posedge core_clk);
		skipWrEn <= 1'b0;
		skipExp = 1'b0;
		boot(3'h2, 5, 0, 0);
		boot(3'h3, 2, 1, 1);
		end_of_test();
	end
endmodule : boot_mode_rom_loader_bench
`default_nettype wire

// *** design/blr_byte_fetch.sv ***
// One-outstanding byte fetch unit facing the external boot memory
`timescale 1ns/1ps
`default_nettype none
module blr_byte_fetch (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Sequencer side
	blr_fetch_if.unit        fch,
	// External memory side
	output logic             memRdReq,
	output logic [31:0]      memRdAddr,
	input  wire logic        memRdAck,
	input  wire logic [7:0]  memRdData
);
	logic       busy_r;
	logic       valid_r;
	logic [7:0] data_r;

	assign fch.rdy   = !busy_r;
	assign fch.valid = valid_r;
	assign fch.data  = data_r;
	assign memRdReq  = busy_r;

	// Take a request, hold it until the memory acknowledges
	always_ff @(posedge core_clk) begin
		if (srst) begin
			busy_r    <= 1'b0;
			memRdAddr <= 32'h0000_0000;
		end else if (fch.req && !busy_r) begin
			busy_r    <= 1'b1;
			memRdAddr <= fch.addr;
		end else if (memRdAck) begin
			busy_r    <= 1'b0;
		end
	end

	// Return the byte as a one-cycle pulse
	always_ff @(posedge core_clk) begin
		if (srst) begin
			valid_r <= 1'b0;
			data_r  <= 8'h00;
		end else begin
			valid_r <= busy_r && memRdAck;
			if (busy_r && memRdAck)
				data_r <= memRdData;
		end
	end

	a_req_held: assert property (@(posedge core_clk) disable iff (srst)
		memRdReq && !memRdAck |=> memRdReq && $stable(memRdAddr))
		else $error("fetch request dropped before acknowledge");

	a_ack_gives_byte: assert property (@(posedge core_clk) disable iff (srst)
		memRdReq && memRdAck |=> fch.valid && fch.data == $past(memRdData))
		else $error("acknowledged byte not returned");

endmodule : blr_byte_fetch
`default_nettype wire

// *** design/blr_fetch_if.sv ***
// Byte fetch channel between the boot sequencer and the fetch unit
`timescale 1ns/1ps
`default_nettype none
interface blr_fetch_if;
	logic        req;
	logic [31:0] addr;
	logic        rdy;
	logic        valid;
	logic [7:0]  data;

	modport seq (output req, output addr, input rdy, input valid, input data);
	modport unit (input req, input addr, output rdy, output valid, output data);
endinterface : blr_fetch_if
`default_nettype wire

// *** design/blr_pkg.sv ***
// Constants, types and state codes shared by the boot loader files
// Functional notes
// - Select 000 skips booting and starts execution at 0x2000_0000.
// - Select 001 boots from 8-bit or 16-bit parallel flash.
// - Select 010 boots over the first serial port, 8-bit addressed EEPROM.
// - Select 011 boots over the first serial port, 16-bit addressed EEPROM.
// - Selects 001 to 011 run the on-chip boot sequence, not external code.
// - Select pins are caught at hardware reset and shown in the status.
// - A software reset with status bit 4 set jumps straight to 0xF000_0000.
// - With bit 4 clear the full boot runs whatever the reset type.
// - The full boot first reads the latched select field.
// - The first four bytes at address 0 give the byte count N.
// - N bytes after the count are copied upward from 0xF000_0000.
// - After the N bytes execution moves to 0xF000_0000.
// - Zero blocks fill with zeros, nonzero and final blocks copy data.
package blr_pkg;

	// Boot source select codes
	localparam logic [2:0]  SEL_BYPASS   = 3'h0;
	localparam logic [2:0]  SEL_FLASH    = 3'h1;
	localparam logic [2:0]  SEL_SER8     = 3'h2;
	localparam logic [2:0]  SEL_SER16    = 3'h3;

	// Addresses
	localparam logic [31:0] BYPASS_ADDR  = 32'h2000_0000;
	localparam logic [31:0] L2_START     = 32'hF000_0000;
	localparam logic [31:0] COUNT_ADDR   = 32'h0000_0000;

	// Reset configuration status layout and reset value
	localparam int          CFG_SEL_LSB  = 0;
	localparam int          CFG_SKIP_BIT = 4;
	localparam logic [15:0] CFG_RESET    = 16'h0000;

	// Byte positions while collecting the count and block tags
	localparam logic [3:0]  IDX_COUNT    = 4'h3;
	localparam logic [3:0]  IDX_TAGADDR  = 4'h3;
	localparam logic [3:0]  IDX_TAGCNT   = 4'h7;
	localparam logic [3:0]  IDX_TAGFLAG  = 4'h9;

	// Tag flag bits
	localparam int          FLAG_ZERO    = 0;
	localparam int          FLAG_FINAL   = 1;

	// Memory port kind shown to the external access logic
	localparam logic [1:0]  PORT_PAR     = 2'h0;
	localparam logic [1:0]  PORT_SER8    = 2'h1;
	localparam logic [1:0]  PORT_SER16   = 2'h2;
	localparam logic [1:0]  PORT_NONE    = 2'h3;

	typedef enum logic [3:0] {
		ST_DECIDE = 4'h0,
		ST_COUNT  = 4'h1,
		ST_COPY   = 4'h2,
		ST_TAG    = 4'h3,
		ST_ZFILL  = 4'h4,
		ST_BCOPY  = 4'h5,
		ST_JUMP   = 4'h6,
		ST_RUN    = 4'h7,
		ST_HALT   = 4'h8
	} blr_state_e;

endpackage : blr_pkg

// *** design/boot_mode_rom_loader.sv ***
// Boot source selection and first-stage boot sequencer
`timescale 1ns/1ps
`default_nettype none
module boot_mode_rom_loader (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Mode pins and software controls
	input  wire logic [2:0]  bootSourceSelect,
	input  wire logic        softReset,
	input  wire logic        skipWrEn,
	input  wire logic        skipWrVal,
	input  wire logic        blockLoadEn,
	output logic [15:0]      resetConfigStatus,
	// External boot memory
	output logic             memRdReq,
	output logic [31:0]      memRdAddr,
	input  wire logic        memRdAck,
	input  wire logic [7:0]  memRdData,
	output logic [1:0]       memPortKind,
	// Level-two memory write
	output logic             l2WrEn,
	output logic [31:0]      l2WrAddr,
	output logic [7:0]       l2WrData,
	// Execution control
	output logic             jumpValid,
	output logic [31:0]      jumpAddr,
	output logic             bootBusy,
	output logic             halted
);
	import blr_pkg::*;

	blr_fetch_if fch ();

	blr_state_e  state_r;
	logic [2:0]  selLatch_r;
	logic        skip_r;
	logic        swStart_r;
	logic        pend_r;
	logic [3:0]  idx_r;
	logic [31:0] shift_r;
	logic [31:0] remain_r;
	logic [31:0] src_r;
	logic [31:0] dst_r;
	logic        zeroBlk_r;
	logic        finalBlk_r;
	logic        fetching;
	logic        got;
	logic [31:0] shiftNxt;

	// Little-endian byte collection
	function automatic logic [31:0] shiftIn(input logic [31:0] cur,
			input logic [7:0] b);
		shiftIn = {b, cur[31:8]};
	endfunction : shiftIn

	////////////////////////////////////////////////////////////////////////
	// Fetch unit
	blr_byte_fetch u_fetch (
		.core_clk  (core_clk),
		.srst      (srst),
		.fch       (fch.unit),
		.memRdReq  (memRdReq),
		.memRdAddr (memRdAddr),
		.memRdAck  (memRdAck),
		.memRdData (memRdData)
	);

	// One byte outstanding at a time while reading the image
	assign fetching = (state_r == ST_COUNT) || (state_r == ST_COPY) ||
		(state_r == ST_TAG) || (state_r == ST_BCOPY);
	assign fch.req  = fetching && !pend_r;
	assign fch.addr = src_r;
	assign got      = fch.valid && pend_r;
	assign shiftNxt = shiftIn(shift_r, fch.data);

	always_ff @(posedge core_clk) begin
		if (srst || softReset)
			pend_r <= 1'b0;
		else if (fch.req && fch.rdy)
			pend_r <= 1'b1;
		else if (fch.valid)
			pend_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration status: pins caught at hardware reset
	always_ff @(posedge core_clk) begin
		if (srst)
			selLatch_r <= bootSourceSelect;
	end

	// Skip bit survives software reset, cleared by hardware reset
	always_ff @(posedge core_clk) begin
		if (srst)
			skip_r <= CFG_RESET[CFG_SKIP_BIT];
		else if (skipWrEn)
			skip_r <= skipWrVal;
	end

	always_comb begin
		resetConfigStatus = CFG_RESET;
		resetConfigStatus[CFG_SEL_LSB +: 3] = selLatch_r;
		resetConfigStatus[CFG_SKIP_BIT] = skip_r;
	end

	// Remember which reset started the sequence
	always_ff @(posedge core_clk) begin
		if (srst)
			swStart_r <= 1'b0;
		else if (softReset)
			swStart_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge core_clk) begin
		if (srst || softReset) begin
			state_r <= ST_DECIDE;
		end else begin
			case (state_r)
				ST_DECIDE: begin
					if (swStart_r && skip_r)
						state_r <= ST_JUMP;
					else case (selLatch_r)
						SEL_BYPASS: state_r <= ST_JUMP;
						SEL_FLASH, SEL_SER8, SEL_SER16:
							state_r <= ST_COUNT;
						default:    state_r <= ST_HALT;
					endcase
				end
				ST_COUNT: begin
					if (got && idx_r == IDX_COUNT)
						state_r <= (shiftNxt == 32'h0000_0000) ?
							(blockLoadEn ? ST_TAG : ST_JUMP) : ST_COPY;
				end
				ST_COPY: begin
					if (got && remain_r == 32'h0000_0001)
						state_r <= blockLoadEn ? ST_TAG : ST_JUMP;
				end
				ST_TAG: begin
					if (got && idx_r == IDX_TAGFLAG) begin
						if (remain_r == 32'h0000_0000)
							state_r <= shiftNxt[16 + FLAG_FINAL] ?
								ST_JUMP : ST_TAG;
						else if (shiftNxt[16 + FLAG_ZERO])
							state_r <= ST_ZFILL;
						else
							state_r <= ST_BCOPY;
					end
				end
				ST_ZFILL, ST_BCOPY: begin
					if ((state_r == ST_ZFILL || got) &&
							remain_r == 32'h0000_0001)
						state_r <= finalBlk_r ? ST_JUMP : ST_TAG;
				end
				ST_JUMP:  state_r <= ST_RUN;
				ST_RUN:   state_r <= ST_RUN;
				ST_HALT:  state_r <= ST_HALT;
				default:  state_r <= ST_HALT;
			endcase
		end
	end

	// Byte index and collecting register for count and tags
	always_ff @(posedge core_clk) begin
		if (srst || softReset || state_r == ST_DECIDE) begin
			idx_r   <= 4'h0;
			shift_r <= 32'h0000_0000;
		end else if (got && (state_r == ST_COUNT || state_r == ST_TAG)) begin
			shift_r <= shiftNxt;
			// Restart at the count's end too, so a zero count enters tags clean
			idx_r   <= (idx_r == IDX_TAGFLAG ||
				(state_r == ST_COUNT && idx_r == IDX_COUNT)) ?
				4'h0 : idx_r + 4'h1;
		end else if (state_r != ST_COUNT && state_r != ST_TAG) begin
			idx_r   <= 4'h0;
		end
	end

	// Source address walks the image from the count onward
	always_ff @(posedge core_clk) begin
		if (srst || softReset || state_r == ST_DECIDE)
			src_r <= COUNT_ADDR;
		else if (fch.req && fch.rdy)
			src_r <= src_r + 32'h0000_0001;
	end

	// Remaining byte count, destination and tag flags
	always_ff @(posedge core_clk) begin
		if (srst || softReset) begin
			remain_r   <= 32'h0000_0000;
			dst_r      <= L2_START;
			zeroBlk_r  <= 1'b0;
			finalBlk_r <= 1'b0;
		end else if (state_r == ST_DECIDE) begin
			dst_r <= L2_START;
		end else if (got && state_r == ST_COUNT && idx_r == IDX_COUNT) begin
			remain_r <= shiftNxt;
		end else if (got && state_r == ST_TAG) begin
			if (idx_r == IDX_TAGADDR)
				dst_r <= shiftNxt;
			if (idx_r == IDX_TAGCNT)
				remain_r <= shiftNxt;
			if (idx_r == IDX_TAGFLAG) begin
				zeroBlk_r  <= shiftNxt[16 + FLAG_ZERO];
				finalBlk_r <= shiftNxt[16 + FLAG_FINAL];
			end
		end else if (state_r == ST_ZFILL ||
				(got && (state_r == ST_COPY || state_r == ST_BCOPY))) begin
			remain_r <= remain_r - 32'h0000_0001;
			dst_r    <= dst_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Level-two writes, registered
	always_ff @(posedge core_clk) begin
		if (srst || softReset) begin
			l2WrEn   <= 1'b0;
			l2WrAddr <= L2_START;
			l2WrData <= 8'h00;
		end else begin
			l2WrEn <= state_r == ST_ZFILL ||
				(got && (state_r == ST_COPY || state_r == ST_BCOPY));
			if (state_r == ST_ZFILL) begin
				l2WrAddr <= dst_r;
				l2WrData <= 8'h00;
			end else if (got) begin
				l2WrAddr <= dst_r;
				l2WrData <= fch.data;
			end
		end
	end

	// Jump target and one-cycle jump pulse
	always_ff @(posedge core_clk) begin
		if (srst || softReset) begin
			jumpValid <= 1'b0;
			jumpAddr  <= L2_START;
		end else begin
			jumpValid <= state_r == ST_JUMP;
			if (state_r == ST_JUMP)
				jumpAddr <= (!(swStart_r && skip_r) &&
					selLatch_r == SEL_BYPASS) ? BYPASS_ADDR : L2_START;
		end
	end

	// Port kind for the external access logic
	always_comb begin
		case (selLatch_r)
			SEL_FLASH: memPortKind = PORT_PAR;
			SEL_SER8:  memPortKind = PORT_SER8;
			SEL_SER16: memPortKind = PORT_SER16;
			default:   memPortKind = PORT_NONE;
		endcase
	end

	assign bootBusy = state_r != ST_RUN && state_r != ST_HALT;
	assign halted   = state_r == ST_HALT;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_bypass_target: assert property (@(posedge core_clk)
		disable iff (srst || softReset)
		state_r == ST_DECIDE && !(swStart_r && skip_r) &&
		selLatch_r == SEL_BYPASS |-> ##2 jumpValid && jumpAddr == BYPASS_ADDR)
		else $error("bypass did not jump to external bank");

	a_reserved_halt: assert property (@(posedge core_clk)
		disable iff (srst || softReset)
		state_r == ST_DECIDE && !(swStart_r && skip_r) && selLatch_r[2]
		|=> halted && !memRdReq && !jumpValid)
		else $error("reserved select did not halt");

	a_skip_jump: assert property (@(posedge core_clk)
		disable iff (srst || softReset)
		state_r == ST_DECIDE && swStart_r && skip_r
		|-> ##2 jumpValid && jumpAddr == L2_START)
		else $error("software skip did not jump to level two");

	a_pins_caught: assert property (@(posedge core_clk)
		$fell(srst) |-> resetConfigStatus[2:0] == $past(bootSourceSelect))
		else $error("select pins not captured at reset");

	a_hw_full_boot: assert property (@(posedge core_clk)
		disable iff (srst || softReset)
		state_r == ST_DECIDE && !swStart_r && selLatch_r == SEL_FLASH
		|=> state_r == ST_COUNT)
		else $error("hardware reset did not run full boot");

	a_count_first: assert property (@(posedge core_clk)
		disable iff (srst || softReset)
		state_r == ST_DECIDE && !(swStart_r && skip_r) &&
		selLatch_r == SEL_SER8 |-> ##2 memRdReq && memRdAddr == COUNT_ADDR)
		else $error("count not read from address zero");

	a_write_ascend: assert property (@(posedge core_clk)
		disable iff (srst || softReset)
		l2WrEn ##1 l2WrEn |-> l2WrAddr == $past(l2WrAddr) + 32'h0000_0001)
		else $error("level two writes not ascending");

	a_jump_after_copy: assert property (@(posedge core_clk)
		disable iff (srst || softReset)
		state_r == ST_COPY && got && remain_r == 32'h0000_0001 && !blockLoadEn
		|-> ##2 jumpValid && jumpAddr == L2_START)
		else $error("no jump after last byte");

endmodule : boot_mode_rom_loader
`default_nettype wire
